// [src/asirx_top.sv]
/*
  Receive slot mapper for channels one to three of the primary audio
  serial port. Holds the three channel registers, deserialises both
  data pins on the bit clock, and hands selected slots to DAC paths.
  Assumes a synchronous 8-bit register port on clock; the pin selects
  and format come from neighbouring logic on the same clock.
*/
// Notes on behaviour
// - bit 5 of register one enables channel one
// - bit 5 of register two enables channel two
// - bit 5 of register three enables channel three
// - bits 7-6 reserved, read zero, host writes zero
// - register one resets to 0x20
// - register two resets to 0x21
// - register three resets to 0x02
// - pin select picks primary or secondary data
`timescale 1ns/1ps
`default_nettype none
module asirx_top
  import asirx_pkg::*;
(
  // System clock and reset
  input  wire logic                             clock,
  input  wire logic                             resetn,
  // Register port
  input  wire asirx_pkg::asirx_reg_req_t        reg_req,
  output logic [7:0]                            reg_rdata,
  // Configuration from neighbouring logic
  input  wire asirx_pkg::asirx_fmt_t            frame_format,
  input  wire logic [2:0]                       pin_select,
  // Serial link
  input  wire logic                             bclk,
  input  wire logic                             fsync,
  input  wire logic                             serial_data_in,
  input  wire logic                             secondary_serial_data_in,
  // DAC channel outputs
  output var asirx_pkg::asirx_sample_t [2:0]    dac_sample
);
  import asirx_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Channel registers

  logic [7:0] cfg_q [ASIRX_NCH];
  logic [7:0] cfg_ofs [ASIRX_NCH];
  logic [ASIRX_NCH-1:0] hit;

  // Offsets of the three channel registers
  assign cfg_ofs[0] = ASIRX_OFS_CH_ONE;
  assign cfg_ofs[1] = ASIRX_OFS_CH_TWO;
  assign cfg_ofs[2] = ASIRX_OFS_CH_THREE;

  genvar g;
  generate
    for (g = 0; g < ASIRX_NCH; g++) begin : g_reg
      assign hit[g] = (reg_req.addr == cfg_ofs[g]);
      // Reserved bits masked off on write
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          case (g)
            0:       cfg_q[g] <= ASIRX_RST_CH_ONE;
            1:       cfg_q[g] <= ASIRX_RST_CH_TWO;
            default: cfg_q[g] <= ASIRX_RST_CH_THREE;
          endcase
        end else if (reg_req.wr && hit[g]) begin
          cfg_q[g] <= reg_req.wdata & ASIRX_WRITE_MASK;
        end
      end
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_sel;
  assign rd_sel = hit[0] ? cfg_q[0] :
                  hit[1] ? cfg_q[1] :
                  hit[2] ? cfg_q[2] : 8'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_sel & ASIRX_WRITE_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Link side: one deserialiser per data pin

  logic [ASIRX_WORD_W-1:0] lw_pri;
  logic [ASIRX_WORD_W-1:0] lw_sec;
  logic [ASIRX_SLOT_W-1:0] ls_pri;
  logic [ASIRX_SLOT_W-1:0] ls_sec;
  logic                    lt_pri;
  logic                    lt_sec;

  asirx_slot_rx u_rx_pri (
    .bclk     (bclk),
    .resetn   (resetn),
    .fsync    (fsync),
    .din      (serial_data_in),
    .word     (lw_pri),
    .slot     (ls_pri),
    .word_tgl (lt_pri)
  );

  asirx_slot_rx u_rx_sec (
    .bclk     (bclk),
    .resetn   (resetn),
    .fsync    (fsync),
    .din      (secondary_serial_data_in),
    .word     (lw_sec),
    .slot     (ls_sec),
    .word_tgl (lt_sec)
  );

  //////////////////////////////////////////////////////////////////////
  // Crossing: toggle synchronised, word held stable for a whole slot

  logic tp_s;
  logic ts_s;
  logic tp_d_q;
  logic ts_d_q;
  logic new_pri;
  logic new_sec;

  asirx_sync u_sync_pri (
    .clock  (clock),
    .resetn (resetn),
    .din    (lt_pri),
    .dout   (tp_s)
  );

  asirx_sync u_sync_sec (
    .clock  (clock),
    .resetn (resetn),
    .din    (lt_sec),
    .dout   (ts_s)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tp_d_q <= 1'b0;
      ts_d_q <= 1'b0;
    end else begin
      tp_d_q <= tp_s;
      ts_d_q <= ts_s;
    end
  end

  assign new_pri = tp_s ^ tp_d_q;
  assign new_sec = ts_s ^ ts_d_q;

  // Capture the stable link words on the toggle edge
  logic [ASIRX_WORD_W-1:0] wp_q;
  logic [ASIRX_WORD_W-1:0] ws_q;
  logic [ASIRX_SLOT_W-1:0] sp_q;
  logic [ASIRX_SLOT_W-1:0] ss_q;
  logic                    vp_q;
  logic                    vs_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      ws_q <= '0;
      sp_q <= '0;
      ss_q <= '0;
      vp_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      vp_q <= new_pri;
      vs_q <= new_sec;
      if (new_pri) begin
        wp_q <= lw_pri;
        sp_q <= ls_pri;
      end
      if (new_sec) begin
        ws_q <= lw_sec;
        ss_q <= ls_sec;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Slot matching and delivery per channel

  logic tdm_mode;
  assign tdm_mode = (frame_format == ASIRX_FMT_TDM);

  // Half-frame slot index: I2S/LJ slot counts run across the frame,
  // so left slot n is index n and right slot n is index 16+n
  generate
    for (g = 0; g < ASIRX_NCH; g++) begin : g_ch
      logic [ASIRX_SLOT_W-1:0] want;
      logic                    en;
      logic                    use_sec;
      logic                    match;
      logic                    vld;
      logic [ASIRX_WORD_W-1:0] w;
      logic [ASIRX_SLOT_W-1:0] s;

      assign en      = cfg_q[g][ASIRX_ENABLE_BIT];
      assign use_sec = pin_select[g];
      assign vld     = use_sec ? vs_q : vp_q;
      assign w       = use_sec ? ws_q : wp_q;
      assign s       = use_sec ? ss_q : sp_q;
      // TDM direct index; half formats split at bit 4
      assign want = tdm_mode ? cfg_q[g][ASIRX_SLOT_W-1:0]
                  : ((cfg_q[g][4] ? ASIRX_HALF_SEL : 5'h00)
                     | {1'b0, cfg_q[g][3:0]});
      assign match = en && vld && (s == want);

      // Same shared word reaches every channel matching the same slot on the same pin
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          dac_sample[g] <= '0;
        end else begin
          dac_sample[g].valid <= match;
          if (match) begin
            dac_sample[g].word <= w;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [src/asirx_pkg.sv]
/*
  Shared constants and carrier types for the receive slot mapper of the
  primary audio serial port, first three playback channels.
  Assumes an 8-bit register port with 8-bit addresses.
*/
package asirx_pkg;

  // Register offsets
  localparam logic [7:0] ASIRX_OFS_CH_ONE   = 8'h28;
  localparam logic [7:0] ASIRX_OFS_CH_TWO   = 8'h29;
  localparam logic [7:0] ASIRX_OFS_CH_THREE = 8'h2a;

  // Values after reset
  localparam logic [7:0] ASIRX_RST_CH_ONE   = 8'h20;
  localparam logic [7:0] ASIRX_RST_CH_TWO   = 8'h21;
  localparam logic [7:0] ASIRX_RST_CH_THREE = 8'h02;

  // Field positions inside a channel register
  localparam int ASIRX_ENABLE_BIT = 5;
  localparam int ASIRX_SLOT_LSB   = 0;
  localparam int ASIRX_SLOT_W     = 5;
  localparam logic [7:0] ASIRX_WRITE_MASK = 8'h3f;

  // Slot and word sizing
  localparam int ASIRX_NCH     = 3;
  localparam int ASIRX_WORD_W  = 32;
  localparam int ASIRX_BITCNT_W = 5;
  localparam logic [4:0] ASIRX_LAST_BIT = 5'h1f;
  localparam logic [4:0] ASIRX_HALF_SEL = 5'h10;

  // Frame formats
  typedef enum logic [2:0] {
    ASIRX_FMT_TDM = 3'h1,
    ASIRX_FMT_I2S = 3'h2,
    ASIRX_FMT_LJ  = 3'h4
  } asirx_fmt_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asirx_reg_req_t;

  // One channel's configuration
  typedef struct packed {
    logic       enable;
    logic       pin_sel;
    logic [4:0] slot;
  } asirx_ch_cfg_t;

  // One delivered sample toward a DAC channel
  typedef struct packed {
    logic                    valid;
    logic [ASIRX_WORD_W-1:0] word;
  } asirx_sample_t;

endpackage

// [src/asirx_sync.sv]
/*
  Two-flop level synchroniser.
  Assumes the input is a level that stays put for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module asirx_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // Second flop alone reads the first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [src/asirx_slot_rx.sv]
/*
  Bit-clock side slot deserialiser for one data pin.
  Assumes frame sync marks slot 0 MSB in every format (TDM, LJ, I2S),
  and that word length is the full 32-bit slot.
*/
`timescale 1ns/1ps
`default_nettype none
module asirx_slot_rx
  import asirx_pkg::*;
(
  // Link clock and reset
  input  wire logic                    bclk,
  input  wire logic                    resetn,
  // Serial inputs
  input  wire logic                    fsync,
  input  wire logic                    din,
  // Deserialised slot
  output logic [ASIRX_WORD_W-1:0]      word,
  output logic [ASIRX_SLOT_W-1:0]      slot,
  output logic                         word_tgl
);
  logic [ASIRX_WORD_W-1:0]   shift_q;
  logic [ASIRX_BITCNT_W-1:0] bit_q;
  logic [ASIRX_SLOT_W-1:0]   slot_q;
  logic                      fs_q;
  logic                      frame_start;
  logic                      last_bit;

  // Frame starts on rising edge of frame sync
  assign frame_start = fsync & ~fs_q;
  assign last_bit    = (bit_q == ASIRX_LAST_BIT);

  // Shift MSB first; publish each complete slot with a toggle
  always_ff @(posedge bclk or negedge resetn) begin
    if (!resetn) begin
      shift_q  <= '0;
      bit_q    <= '0;
      slot_q   <= '0;
      fs_q     <= 1'b0;
      word     <= '0;
      slot     <= '0;
      word_tgl <= 1'b0;
    end else begin
      fs_q    <= fsync;
      shift_q <= {shift_q[ASIRX_WORD_W-2:0], din};
      if (frame_start) begin
        bit_q  <= 5'h01;
        slot_q <= '0;
        shift_q <= {{(ASIRX_WORD_W-1){1'b0}}, din};
      end else begin
        bit_q <= bit_q + 5'h01;
        if (last_bit) begin
          slot_q   <= slot_q + 5'h01;
          word     <= {shift_q[ASIRX_WORD_W-2:0], din};
          slot     <= slot_q;
          word_tgl <= ~word_tgl;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/asirx_chk.sv]
/*
  Port checker for the slot mapper: register reads, channel gating and
  shared-slot words. Assumes it is bound into asirx_top.
*/
`timescale 1ns/1ps
`default_nettype none
module asirx_chk
  import asirx_pkg::*;
(
  // Clock and reset
  input wire logic                           clock,
  input wire logic                           resetn,
  // Watched ports
  input wire asirx_pkg::asirx_reg_req_t      reg_req,
  input wire logic [7:0]                     reg_rdata,
  input wire logic [2:0]                     pin_select,
  input wire asirx_pkg::asirx_sample_t [2:0] dac_sample
);
  import asirx_pkg::*;
  logic [7:0] cfg_q [3];
  // Address decode of the watched requests
  wire  w1 = reg_req.wr && reg_req.addr == ASIRX_OFS_CH_ONE;
  wire  w2 = reg_req.wr && reg_req.addr == ASIRX_OFS_CH_TWO;
  wire  w3 = reg_req.wr && reg_req.addr == ASIRX_OFS_CH_THREE;
  wire  hit = reg_req.addr inside {[8'h28:8'h2a]};
  // Shadow of the three channel registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q[0] <= ASIRX_RST_CH_ONE;
      cfg_q[1] <= ASIRX_RST_CH_TWO;
      cfg_q[2] <= ASIRX_RST_CH_THREE;
    end else begin
      if (w1) cfg_q[0] <= reg_req.wdata & ASIRX_WRITE_MASK;
      if (w2) cfg_q[1] <= reg_req.wdata & ASIRX_WRITE_MASK;
      if (w3) cfg_q[2] <= reg_req.wdata & ASIRX_WRITE_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_rd(a);
    reg_req.addr == a && !reg_req.wr;
  endsequence
  a_resvd_zero: assert property (reg_rdata[7:6] == 2'h0)
    else $error("reserved read bits set");
  a_unmapped_zero: assert property (!hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ch_one_read: assert property
    (s_rd(ASIRX_OFS_CH_ONE) |=> reg_rdata == cfg_q[0])
    else $error("channel one read wrong");
  a_ch_two_read: assert property
    (s_rd(ASIRX_OFS_CH_TWO) |=> reg_rdata == cfg_q[1])
    else $error("channel two read wrong");
  a_ch_three_read: assert property
    (s_rd(ASIRX_OFS_CH_THREE) |=> reg_rdata == cfg_q[2])
    else $error("channel three read wrong");
  a_ch_one_gate: assert property (dac_sample[0].valid |-> cfg_q[0][5])
    else $error("disabled channel one delivered");
  a_ch_two_gate: assert property (dac_sample[1].valid |-> cfg_q[1][5])
    else $error("disabled channel two delivered");
  a_ch_three_gate: assert property (dac_sample[2].valid |-> cfg_q[2][5])
    else $error("disabled channel three delivered");
  a_pulse_single: assert property
    (dac_sample[1].valid |=> !dac_sample[1].valid)
    else $error("channel two pulse too long");
  a_shared_word: assert property
    (dac_sample[0].valid && dac_sample[2].valid &&
     cfg_q[0][4:0] == cfg_q[2][4:0] && pin_select[0] == pin_select[2]
     |-> dac_sample[0].word == dac_sample[2].word)
    else $error("shared slot words differ");
endmodule
bind asirx_top asirx_chk chk (.clock(clock), .resetn(resetn),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_select(pin_select),
  .dac_sample(dac_sample));
`default_nettype wire

// [sim/asirx_host.sv]
/*
  Host model: bit clock, frame sync and both data pins.
  Assumes the bench loads pw and sw before each frame.
*/
`timescale 1ns/1ps
`default_nettype none
module asirx_host (
  // Serial link
  output logic bclk,
  output logic fsync,
  output logic sd0,
  output logic sd1
);
  logic [31:0] pw [32];
  logic [31:0] sw [32];
  int          b;
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sd0 = 1'b0;
    sd1 = 1'b1;
  end
  // Free edges, used only while reset is held
  task edges(input int n);
    repeat (n) begin
      bclk = 1'b1;
      #32 bclk = 1'b0;
      #32;
    end
  endtask
  // One frame of 32 slots, MSB first; lead adds the one-bit I2S delay
  task frame(input bit lead);
    for (int e = 0; e < 1024 + lead; e++) begin
      b = e - lead;
      fsync = (b >= 0) && (b < 512);
      sd0 = (b < 0) ? ~sd0 : pw[b/32][31-b%32];
      sd1 = (b < 0) ? ~sd1 : sw[b/32][31-b%32];
      #32 bclk = 1'b1;
      #32 bclk = 1'b0;
    end
    // Released lines no longer show the last bit
    sd0 = ~sd0;
    sd1 = ~sd1;
    fsync = 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
/*
  Self-checking bench for the slot mapper.
  Assumes the host model drives the link and the bench the registers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asirx_pkg::*;
  logic                clock;
  logic                resetn;
  asirx_reg_req_t      req;
  logic [7:0]          rdata;
  asirx_fmt_t          fmt;
  logic [2:0]          psel;
  logic                bclk, fsync, sd0, sd1;
  asirx_sample_t [2:0] dac;
  int                  miscompares, n_checks, r;
  int                  cnt [3];
  logic [31:0]         got [3];
  always #2 clock = ~clock;
  asirx_host host (.bclk(bclk), .fsync(fsync), .sd0(sd0), .sd1(sd1));
  asirx_top uut (.clock(clock), .resetn(resetn), .reg_req(req),
    .reg_rdata(rdata), .frame_format(fmt), .pin_select(psel),
    .bclk(bclk), .fsync(fsync), .serial_data_in(sd0),
    .secondary_serial_data_in(sd1), .dac_sample(dac));
  // Collect delivered samples
  always @(posedge clock) begin
    for (int g = 0; g < 3; g++) begin
      if (dac[g].valid === 1'b1) begin
        cnt[g]++;
        got[g] = dac[g].word;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] a, input logic [31:0] e, input string m);
    n_checks++;
    if (a !== e) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, a, d};
    @(posedge clock);
    #1;
  endtask
  task reg_rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, a, 8'h00};
    @(posedge clock);
    #1 chk({24'h0, rdata}, {24'h0, e}, "register read");
  endtask
  // Slot field is the frame slot index; 16-31 are the right half
  function logic [31:0] ew(input logic [7:0] c, input int g);
    return psel[g] ? host.sw[c[4:0]] : host.pw[c[4:0]];
  endfunction
  task run(input asirx_fmt_t f, input logic [23:0] cf,
           input logic [2:0] p, input string nm);
    int want;
    want = cf[5] + cf[13] + cf[21];
    for (int g = 0; g < 3; g++) reg_wr(8'h28 + 8'(g), cf[8*g+:8] & 8'h3f);
    for (int g = 0; g < 3; g++) reg_rd(8'h28 + 8'(g), cf[8*g+:8] & 8'h3f);
    fmt = f;
    psel = p;
    for (int s = 0; s < 32; s++) begin
      host.pw[s] = $urandom;
      host.sw[s] = $urandom;
    end
    cnt = '{0, 0, 0};
    host.frame(f == ASIRX_FMT_I2S);
    for (int i = 0; i < 60 && cnt[0] + cnt[1] + cnt[2] < want; i++)
      @(posedge clock);
    if (cnt[0] + cnt[1] + cnt[2] < want) begin
      miscompares++;
      $display("[ERR] %0t delivery wait ran out", $time);
      give_verdict();
    end
    repeat (4) @(posedge clock);
    #1;
    for (int g = 0; g < 3; g++) begin
      chk(cnt[g], {31'h0, cf[8*g+5]}, "pulse count");
      if (cf[8*g+5]) chk(got[g], ew(cf[8*g+:8], g), "word");
    end
    $display("test %s done", nm);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    req = '0;
    fmt = ASIRX_FMT_TDM;
    psel = 3'h0;
    miscompares = 0;
    n_checks = 0;
    r = $urandom(51);
    fork
      host.edges(2);
      repeat (20) @(posedge clock);
    join
    #1 resetn = 1'b1;
    reg_rd(8'h28, 8'h20);
    reg_rd(8'h29, 8'h21);
    reg_rd(8'h2a, 8'h02);
    reg_wr(8'h2b, 8'h15);
    reg_rd(8'h2b, 8'h00);
    $display("test reset done");
    run(ASIRX_FMT_TDM, 24'h022120, 3'h0, "tdm_default");
    r = $urandom_range(31);
    run(ASIRX_FMT_TDM, {8'h3f, 8'h20 | 8'(r), 8'h3f}, 3'h2, "shared");
    r = $urandom_range(31);
    run(ASIRX_FMT_LJ, {8'h20 | 8'(r), 8'h2f, 8'h10}, 3'h5, "lj");
    r = $urandom_range(31);
    run(ASIRX_FMT_I2S, {8'h3f, 8'h30, 8'h20 | 8'(r)}, 3'($urandom), "i2s");
    give_verdict();
  end
endmodule
`default_nettype wire
